// *** hw/ext_bus_pkg.sv ***
package ext_bus_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // Clock and transfer timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS = 16;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYCLES - 1);
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;
  localparam logic [11:0] REFRESH_LAST = 12'(REFRESH_CYCLES - 1);

  // Lane codes and reset values; lane enables are {upper, lower}, active low
  localparam logic [1:0] LANES_OFF = 2'h3;
  localparam logic [1:0] LANES_BOTH = 2'h0;
  localparam logic [1:0] LANES_LOWER = 2'h2;
  localparam logic [1:0] LANES_UPPER = 2'h1;
  localparam logic [17:0] PIN_SYNC_RESET = 18'h30000;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_STROBE = 3'h2,
    S_RELEASE = 3'h3,
    S_GRANT = 3'h4
  } bus_state_type;

  typedef struct packed {
    bus_state_type state;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] dout;
    logic [15:0] rdata;
    logic write;
    logic io;
    logic refresh;
    logic word;
    logic second;
    logic [1:0] lanes_n;
    logic [2:0] cnt;
    logic rsp;
    logic [11:0] rcnt;
    logic rpend;
    logic ack_n;
  } bus_regs_type;

endpackage

// *** hw/external_bus_sizing_and_grant.sv ***
`timescale 1ns/1ns
// Behaviour
// - Drive 24-bit non-multiplexed address, 16 MB space.
// - I/O transactions use the same address lines.
// - On bus request, tri-state, then assert acknowledge.
// - No refresh while bus acknowledge is asserted.
// - Assert upper lane enable for upper-lane transactions (I/O transactions here leave both lane enables negated).
// - Byte-wide memory splits word into a word transfer, then an odd-byte lower-lane transfer.
// - Slash-named signals active low, others active high.
// - Assert lower lane enable for lower-lane transactions (I/O transactions here leave both lane enables negated).
// - Even byte on lower lane, odd on upper.
module external_bus_sizing_and_grant (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Core request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic req_word,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_wdata,
  // Core answer port
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // Address bus
  output logic [23:0] addr_out,
  output logic addr_oe_n,
  // Data bus
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Bus control strobes
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  output logic mem_read_n,
  output logic mem_write_n,
  output logic io_request_n,
  output logic io_read_n,
  output logic io_write_n,
  output logic refresh_strobe_n,
  output logic strobe_oe_n,
  // Sizing and bus hand-over
  input wire logic byte_wide_memory_ind_n,
  input wire logic bus_hold_request_n,
  output logic bus_grant_ack_n
);

  ext_bus_pkg::bus_regs_type r_reg;
  ext_bus_pkg::bus_regs_type r_next;
  logic [17:0] pins_s;
  logic hold_s;
  logic ind_s;
  logic [15:0] din_s;
  logic granted;
  logic last_cycle;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  pin_sync #(
    .WIDTH(18),
    .RESET_VALUE(ext_bus_pkg::PIN_SYNC_RESET)
  ) i_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({bus_hold_request_n, byte_wide_memory_ind_n, data_in}),
    .sync_out(pins_s)
  );

  // Active-low pins are turned into asserted-high flags here only
  assign hold_s = !pins_s[17];
  assign ind_s = !pins_s[16];
  assign din_s = pins_s[15:0];

  assign granted = (r_reg.state == ext_bus_pkg::S_RELEASE) ||
                   (r_reg.state == ext_bus_pkg::S_GRANT);
  assign last_cycle = (r_reg.state == ext_bus_pkg::S_STROBE) &&
                      (r_reg.cnt == ext_bus_pkg::STROBE_LAST);

  // A pending refresh blocks new requests so refresh cannot starve
  assign req_ready = (r_reg.state == ext_bus_pkg::S_IDLE) && !hold_s && !r_reg.rpend;

  always_comb begin
    r_next = r_reg;
    r_next.rsp = 1'b0;
    unique case (r_reg.state)
      ext_bus_pkg::S_IDLE: begin
        r_next.lanes_n = ext_bus_pkg::LANES_OFF;
        r_next.cnt = 3'h0;
        r_next.second = 1'b0;
        if (hold_s) begin
          r_next.state = ext_bus_pkg::S_RELEASE;
        end else if (r_reg.rpend) begin
          r_next.state = ext_bus_pkg::S_ADDR;
          r_next.refresh = 1'b1;
          r_next.write = 1'b0;
          r_next.io = 1'b0;
          r_next.word = 1'b1;
          r_next.rpend = 1'b0;
          r_next.lanes_n = ext_bus_pkg::LANES_BOTH;
        end else if (req_valid) begin
          r_next.state = ext_bus_pkg::S_ADDR;
          r_next.refresh = 1'b0;
          r_next.write = req_write;
          r_next.io = req_io;
          r_next.word = req_word;
          r_next.wdata = req_wdata;
          r_next.rdata = 16'h0000;
          // Same address lines for memory and I/O; words are even-aligned
          r_next.addr = {req_addr[23:1], req_addr[0] & !req_word};
          if (req_word) begin
            r_next.dout = req_wdata;
          end else if (req_addr[0]) begin
            r_next.dout = {req_wdata[7:0], 8'h00};
          end else begin
            r_next.dout = {8'h00, req_wdata[7:0]};
          end
          if (req_io) begin
            r_next.lanes_n = ext_bus_pkg::LANES_OFF;
          end else if (req_word) begin
            r_next.lanes_n = ext_bus_pkg::LANES_BOTH;
          end else if (req_addr[0]) begin
            r_next.lanes_n = ext_bus_pkg::LANES_UPPER;
          end else begin
            r_next.lanes_n = ext_bus_pkg::LANES_LOWER;
          end
        end
      end
      ext_bus_pkg::S_ADDR: begin
        r_next.state = ext_bus_pkg::S_STROBE;
        r_next.cnt = 3'h0;
      end
      ext_bus_pkg::S_STROBE: begin
        if (r_reg.cnt != ext_bus_pkg::STROBE_LAST) begin
          r_next.cnt = r_reg.cnt + 3'h1;
        end else if (r_reg.word && !r_reg.io && !r_reg.refresh && !r_reg.second && ind_s) begin
          // Byte-wide memory: keep the even byte, then move the odd one on D7-0
          r_next.state = ext_bus_pkg::S_ADDR;
          r_next.second = 1'b1;
          r_next.addr = {r_reg.addr[23:1], 1'b1};
          r_next.dout = {8'h00, r_reg.wdata[15:8]};
          r_next.lanes_n = ext_bus_pkg::LANES_LOWER;
          if (!r_reg.write) begin
            r_next.rdata = {8'h00, din_s[7:0]};
          end
        end else begin
          r_next.state = ext_bus_pkg::S_IDLE;
          r_next.lanes_n = ext_bus_pkg::LANES_OFF;
          r_next.rsp = !r_reg.refresh;
          r_next.refresh = 1'b0;
          if (!r_reg.write && !r_reg.refresh) begin
            if (r_reg.second) begin
              r_next.rdata = {din_s[7:0], r_reg.rdata[7:0]};
            end else if (r_reg.word) begin
              r_next.rdata = din_s;
            end else if (r_reg.addr[0]) begin
              r_next.rdata = {8'h00, din_s[15:8]};
            end else begin
              r_next.rdata = {8'h00, din_s[7:0]};
            end
          end
        end
      end
      ext_bus_pkg::S_RELEASE: begin
        // Drivers went to high impedance on entry; acknowledge follows
        r_next.state = ext_bus_pkg::S_GRANT;
        r_next.ack_n = 1'b0;
      end
      ext_bus_pkg::S_GRANT: begin
        if (!hold_s) begin
          r_next.state = ext_bus_pkg::S_IDLE;
          r_next.ack_n = 1'b1;
        end
      end
      default: begin
        r_next.state = ext_bus_pkg::S_IDLE;
      end
    endcase
    // Refresh tick is counted even while granted, but only issued from idle
    if (r_reg.rcnt == ext_bus_pkg::REFRESH_LAST) begin
      r_next.rcnt = 12'h000;
      r_next.rpend = 1'b1;
    end else begin
      r_next.rcnt = r_reg.rcnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '{state: ext_bus_pkg::S_IDLE, lanes_n: ext_bus_pkg::LANES_OFF,
                 ack_n: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rsp_valid = r_reg.rsp;
  assign rsp_rdata = r_reg.rdata;
  assign addr_out = r_reg.addr;
  assign addr_oe_n = granted;
  assign strobe_oe_n = granted;
  assign data_out = r_reg.dout;
  assign data_oe_n = granted || !r_reg.write ||
                     !((r_reg.state == ext_bus_pkg::S_ADDR) ||
                       (r_reg.state == ext_bus_pkg::S_STROBE));
  assign upper_lane_enable_n = r_reg.lanes_n[1];
  assign lower_lane_enable_n = r_reg.lanes_n[0];
  assign mem_read_n = !((r_reg.state == ext_bus_pkg::S_STROBE) && !r_reg.io &&
                        !r_reg.refresh && !r_reg.write);
  assign mem_write_n = !((r_reg.state == ext_bus_pkg::S_STROBE) && !r_reg.io &&
                         !r_reg.refresh && r_reg.write);
  assign io_request_n = !(r_reg.io && ((r_reg.state == ext_bus_pkg::S_ADDR) ||
                                       (r_reg.state == ext_bus_pkg::S_STROBE)));
  assign io_read_n = !((r_reg.state == ext_bus_pkg::S_STROBE) && r_reg.io && !r_reg.write);
  assign io_write_n = !((r_reg.state == ext_bus_pkg::S_STROBE) && r_reg.io && r_reg.write);
  assign refresh_strobe_n = !((r_reg.state == ext_bus_pkg::S_STROBE) && r_reg.refresh);
  assign bus_grant_ack_n = r_reg.ack_n;

  sequence split_detect;
    last_cycle && r_reg.word && !r_reg.io && !r_reg.refresh && !r_reg.second && ind_s;
  endsequence

  sequence second_beat;
    (r_reg.state == ext_bus_pkg::S_ADDR) && r_reg.addr[0] && upper_lane_enable_n &&
    !lower_lane_enable_n ##1 !upper_lane_enable_n == 1'b0 [*4];
  endsequence

  a_grant_drivers_off: assert property (!bus_grant_ack_n |-> addr_oe_n && data_oe_n && strobe_oe_n)
    else $error("drivers active while bus is granted");
  a_release_before_ack: assert property ($fell(bus_grant_ack_n) |-> $past(addr_oe_n) && $past(strobe_oe_n))
    else $error("acknowledge asserted before drivers released");
  a_no_granted_refresh: assert property (!bus_grant_ack_n |-> refresh_strobe_n && lower_lane_enable_n)
    else $error("refresh activity while bus is granted");
  a_refresh_both_lanes: assert property (r_reg.refresh && (r_reg.state == ext_bus_pkg::S_ADDR) |->
                                         !upper_lane_enable_n && !lower_lane_enable_n ##1 !refresh_strobe_n)
    else $error("refresh did not enable both lanes");
  a_split_second_beat: assert property (split_detect |=> second_beat)
    else $error("byte-wide word access not split onto lower lane");
  a_even_byte_lane: assert property ((r_reg.state == ext_bus_pkg::S_ADDR) && !r_reg.word && !r_reg.io &&
                                     !r_reg.refresh |-> (upper_lane_enable_n == !r_reg.addr[0]) &&
                                     (lower_lane_enable_n == r_reg.addr[0]))
    else $error("byte placed on wrong lane");
  // Refresh reuses the last address, so only core words must be even
  a_word_lanes: assert property ((r_reg.state == ext_bus_pkg::S_ADDR) && r_reg.word && !r_reg.io &&
                                 !r_reg.second |-> (r_reg.refresh || !r_reg.addr[0]) &&
                                 !upper_lane_enable_n && !lower_lane_enable_n)
    else $error("word transfer lanes wrong");
  a_ack_held: assert property (!bus_grant_ack_n && hold_s |=> !bus_grant_ack_n)
    else $error("acknowledge dropped while request held");
  a_ack_retake: assert property (!bus_grant_ack_n && !hold_s |=>
                                 bus_grant_ack_n && !addr_oe_n && !strobe_oe_n)
    else $error("bus not retaken after request removed");
  a_grant_latency: assert property ($rose(hold_s) && (r_reg.state == ext_bus_pkg::S_IDLE) |->
                                    ##[1:2] !bus_grant_ack_n)
    else $error("acknowledge late after request");
  a_addr_steady: assert property ((r_reg.state == ext_bus_pkg::S_STROBE) |-> $stable(addr_out))
    else $error("address changed during strobe");
  a_io_addr_lines: assert property ((r_reg.state == ext_bus_pkg::S_ADDR) && r_reg.io |->
                                    !io_request_n && !addr_oe_n && lower_lane_enable_n)
    else $error("I/O cycle not on address lines");

endmodule

// *** hw/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 18,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins in, synchronised copy out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_regs_type;

  sync_regs_type r_reg;
  sync_regs_type r_next;

  // The first stage feeds the second stage only
  always_comb begin
    r_next.meta = async_in;
    r_next.sync = r_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_reg <= '{meta: RESET_VALUE, sync: RESET_VALUE};
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.sync;

endmodule

// *** tb/mem_model.sv ***
`timescale 1ns/1ns
module mem_model (
  // Clock and memory width
  input wire logic clk,
  input wire logic narrow,
  // Bus from the device
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic mem_write_n,
  // Bus back to the device
  output logic [15:0] data_in,
  output logic byte_wide_memory_ind_n
);
  logic [7:0] mem [256];
  logic [15:0] last;
  logic act;
  logic [7:0] ev;
  assign act = !(upper_lane_enable_n && lower_lane_enable_n);
  assign ev = {addr_out[7:1], 1'b0};
  // Pulled up, so the pin reads negated outside our own cycles
  assign byte_wide_memory_ind_n = !(narrow && act);
  // Undriven lanes show the inverse of the last value, never a friendly stale copy
  always_comb begin
    if (!act) data_in = ~last;
    else if (narrow) data_in = {~last[15:8], mem[addr_out[7:0]]};
    else data_in = {mem[ev + 8'h01], mem[ev]};
  end
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    last = 16'h0000;
  end
  always @(posedge clk) begin
    if (act) last <= data_in;
    if (!mem_write_n && narrow) mem[addr_out[7:0]] <= data_out[7:0];
    else if (!mem_write_n) begin
      if (!lower_lane_enable_n) mem[ev] <= data_out[7:0];
      if (!upper_lane_enable_n) mem[ev + 8'h01] <= data_out[15:8];
    end
  end
endmodule

// *** tb/test_external_bus_sizing_and_grant.sv ***
`timescale 1ns/1ns
module test_external_bus_sizing_and_grant;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_io = 1'b0, req_word = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic bus_hold_request_n = 1'b1, narrow = 1'b0;
  logic req_ready, rsp_valid, addr_oe_n, data_oe_n, upper_lane_enable_n, lower_lane_enable_n;
  logic mem_read_n, mem_write_n, io_request_n, io_read_n, io_write_n, refresh_strobe_n;
  logic strobe_oe_n, byte_wide_memory_ind_n, bus_grant_ack_n;
  logic [15:0] rsp_rdata, data_in, data_out;
  logic [23:0] addr_out;
  int mismatches = 0, n_tests = 0;
  int nstrobe, up_seen, lo_seen, io_seen, drv_seen;
  always #2 clk = ~clk;
  external_bus_sizing_and_grant i_external_bus_sizing_and_grant (.clk, .resetn, .req_valid,
    .req_ready, .req_write, .req_io, .req_word, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .addr_out, .addr_oe_n, .data_in, .data_out, .data_oe_n, .upper_lane_enable_n,
    .lower_lane_enable_n, .mem_read_n, .mem_write_n, .io_request_n, .io_read_n, .io_write_n,
    .refresh_strobe_n, .strobe_oe_n, .byte_wide_memory_ind_n, .bus_hold_request_n,
    .bus_grant_ack_n);
  mem_model i_mem_model (.clk, .narrow, .addr_out, .data_out, .upper_lane_enable_n,
    .lower_lane_enable_n, .mem_write_n, .data_in, .byte_wide_memory_ind_n);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Which output a wait watches: 0 ready, 1 acknowledge, 2 refresh strobe
  function automatic logic watched(input int s);
    if (s == 0) return req_ready;
    else if (s == 1) return bus_grant_ack_n;
    else return refresh_strobe_n;
  endfunction
  task automatic wait_for(input int s, input logic lvl, input int lim);
    for (int k = 0; k < lim && watched(s) !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // One core request; counts strobes and lane use until the answer
  task automatic xfer(input logic w, io, wd, input logic [23:0] a, input logic [15:0] d);
    logic ps;
    req_valid = 1'b1;
    req_write = w;
    req_io = io;
    req_word = wd;
    req_addr = a;
    req_wdata = d;
    wait_for(0, 1'b1, 9000);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    nstrobe = 0;
    up_seen = 0;
    lo_seen = 0;
    io_seen = 0;
    drv_seen = 0;
    ps = 1'b1;
    for (int k = 0; k < 40 && rsp_valid !== 1'b1; k++) begin
      if (ps && !(mem_read_n && mem_write_n && io_read_n && io_write_n)) nstrobe++;
      ps = mem_read_n && mem_write_n && io_read_n && io_write_n;
      if (upper_lane_enable_n === 1'b0) up_seen++;
      if (lower_lane_enable_n === 1'b0) lo_seen++;
      if (io_request_n === 1'b0) io_seen++;
      if (data_oe_n === 1'b0) drv_seen++;
      if (!ps) chk(addr_out[23:1], a[23:1]);
      @(posedge clk);
      #1;
    end
    chk(rsp_valid, 1'b1);
  endtask
  task automatic t_reset;
    chk({bus_grant_ack_n, upper_lane_enable_n, lower_lane_enable_n, mem_read_n, mem_write_n,
      refresh_strobe_n, data_oe_n}, 7'h7f);
  endtask
  task automatic t_wide;
    xfer(1'b1, 1'b0, 1'b1, 24'hab0020, 16'hbeef);
    chk({up_seen != 0, lo_seen != 0, 8'(nstrobe), 8'(drv_seen)}, {2'h3, 8'h01, 8'h05});
    xfer(1'b0, 1'b0, 1'b1, 24'hab0020, 16'h0000);
    chk(rsp_rdata, 16'hbeef);
    xfer(1'b0, 1'b0, 1'b1, 24'hfffe10, 16'h0000);
    chk(rsp_rdata, 16'h4b4a);
    xfer(1'b0, 1'b0, 1'b0, 24'h000050, 16'h0000);
    chk({up_seen != 0, lo_seen != 0, 8'(nstrobe), rsp_rdata}, {2'h1, 8'h01, 16'h000a});
    xfer(1'b0, 1'b0, 1'b0, 24'h000051, 16'h0000);
    chk({up_seen != 0, lo_seen != 0, rsp_rdata}, {2'h2, 16'h000b});
    xfer(1'b1, 1'b0, 1'b0, 24'h000061, 16'h0077);
    xfer(1'b0, 1'b0, 1'b1, 24'h000060, 16'h0000);
    chk(rsp_rdata, 16'h773a);
  endtask
  task automatic t_split;
    narrow = 1'b1;
    xfer(1'b0, 1'b0, 1'b1, 24'h000030, 16'h0000);
    chk(rsp_rdata, 16'h6b6a);
    // The first beat is a plain word cycle; only the strobe count and the answer show the memory is narrow
    chk({up_seen != 0, lo_seen != 0, 8'(nstrobe)}, {2'h3, 8'h02});
    xfer(1'b1, 1'b0, 1'b1, 24'h000040, 16'h1234);
    chk({up_seen != 0, lo_seen != 0, 8'(nstrobe)}, {2'h3, 8'h02});
    narrow = 1'b0;
    xfer(1'b0, 1'b0, 1'b1, 24'h000040, 16'h0000);
    chk(rsp_rdata, 16'h1234);
  endtask
  task automatic t_io;
    xfer(1'b0, 1'b1, 1'b0, 24'h123456, 16'h0000);
    chk({up_seen != 0, lo_seen != 0, 8'(nstrobe), 8'(io_seen), 4'(drv_seen)},
      {2'h0, 8'h01, 8'h05, 4'h0});
    xfer(1'b1, 1'b1, 1'b0, 24'h123457, 16'h00a5);
    chk({8'(nstrobe), 8'(io_seen), 8'(drv_seen)}, {8'h01, 8'h05, 8'h05});
  endtask
  // Grant spans a refresh tick; the tick must wait until the bus is back
  task automatic t_grant;
    bus_hold_request_n = 1'b0;
    wait_for(1, 1'b0, 20);
    chk({bus_grant_ack_n, addr_oe_n, data_oe_n, strobe_oe_n}, 4'h7);
    for (int k = 0; k < 4000; k++) begin
      @(posedge clk);
      #1;
      chk({bus_grant_ack_n, refresh_strobe_n, addr_oe_n}, 3'h3);
    end
    bus_hold_request_n = 1'b1;
    wait_for(1, 1'b1, 20);
    chk({bus_grant_ack_n, addr_oe_n, strobe_oe_n}, 3'h4);
    wait_for(2, 1'b0, 50);
    chk({refresh_strobe_n, upper_lane_enable_n, lower_lane_enable_n}, 3'h0);
  endtask
  initial begin
    #(4 * 6000);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    t_reset;
    resetn = 1'b1;
    t_wide;
    t_split;
    t_io;
    t_grant;
    test_done;
  end
endmodule
